// File: logic/ubirq_top.sv
module ubirq_top
  import ubirq_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire ubirq_uart_t uart_in,
  output logic             tick16_out,
  output logic             irq_n_reg,
  output logic             irq_reg
);

  ubirq_ctrl_t      ctrl_reg;
  logic [NSRC-1:0]  evt_reg;
  logic [NSRC-1:0]  evmask_reg;
  logic [NSRC-1:0]  flags;
  logic [NSRC-1:0]  src;
  logic             received_parity_flag;
  logic             line_activity_flag;
  logic             framing_error_flag;
  logic             activity_or_error_bit;
  logic             tx_src_reg;
  logic             tx_empty_q_reg;
  logic             shdn_q_reg;
  logic             rx_q_reg;
  logic             aw_hold_reg;
  logic             w_hold_reg;
  logic [7:0]       awaddr_reg;
  logic [31:0]      wdata_reg;
  logic [3:0]       wstrb_reg;
  logic             wr_fire;
  logic [NSRC-1:0]  evt_clr;
  logic             src_any;

  ubirq_baudgen u_baud (
    .aclk                (aclk),
    .aresetn             (aresetn),
    .divisor_select_code (ctrl_reg.div_code),
    .tick16_reg          (tick16_out)
  );

  // Parity flag taken from the oldest buffered word.
  assign received_parity_flag = ctrl_reg.parity_enable & uart_in.fifo_valid &
                                uart_in.fifo_parity;

  // Data available while the buffer holds data or a read is in progress.
  assign flags[SRC_RX] = uart_in.fifo_valid | uart_in.reading;
  assign flags[SRC_PAR] = received_parity_flag;

  // Shared activity/error bit selected by the shutdown state.
  assign activity_or_error_bit = uart_in.shutdown ? line_activity_flag
                                                  : framing_error_flag;
  assign flags[SRC_AE] = activity_or_error_bit;
  assign flags[SRC_TX] = uart_in.tx_empty;

  // Receive line activity detector for shutdown.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_q_reg           <= 1'b1;
      shdn_q_reg         <= 1'b0;
      line_activity_flag <= 1'b0;
    end
    else
    begin
      rx_q_reg   <= uart_in.rx_line;
      shdn_q_reg <= uart_in.shutdown;
      if (!uart_in.shutdown)
        line_activity_flag <= 1'b0;
      else if (shdn_q_reg && (rx_q_reg != uart_in.rx_line))
        line_activity_flag <= 1'b1;
    end
  end

  // Framing error reflects the last stop bit sampled and clears while in shutdown.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      framing_error_flag <= 1'b0;
    else if (uart_in.shutdown)
      framing_error_flag <= 1'b0;
    else if (uart_in.stop_sampled)
      framing_error_flag <= ~uart_in.stop_bit;
  end

  // Transmit-empty source sets on the empty edge and clears on a data operation.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tx_empty_q_reg <= 1'b1;
      tx_src_reg     <= 1'b0;
    end
    else
    begin
      tx_empty_q_reg <= uart_in.tx_empty;
      if (uart_in.tx_empty && !tx_empty_q_reg)
        tx_src_reg <= 1'b1;
      else if (uart_in.data_op_done)
        tx_src_reg <= 1'b0;
    end
  end

  assign src[SRC_PAR] = received_parity_flag & ctrl_reg.parity_irq_mask;
  assign src[SRC_RX]  = flags[SRC_RX] & ctrl_reg.receive_irq_mask;
  assign src[SRC_AE]  = activity_or_error_bit & ctrl_reg.activity_irq_mask;
  assign src[SRC_TX]  = tx_src_reg & ctrl_reg.tx_empty_irq_mask;
  assign src_any      = |src;

  // Device interrupt pin is a registered, active-low OR of the gated sources, so it goes high the cycle after none hold.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_n_reg <= 1'b1;
    else
      irq_n_reg <= ~src_any;
  end

  // Write channel capture.
  assign wr_fire = aw_hold_reg & w_hold_reg & ~s_axi_bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_reg   <= 1'b0;
      w_hold_reg    <= 1'b0;
      awaddr_reg    <= '0;
      wdata_reg     <= '0;
      wstrb_reg     <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      if (s_axi_awvalid && !aw_hold_reg && !s_axi_awready)
      begin
        s_axi_awready <= 1'b1;
        aw_hold_reg   <= 1'b1;
        awaddr_reg    <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_hold_reg && !s_axi_wready)
      begin
        s_axi_wready <= 1'b1;
        w_hold_reg   <= 1'b1;
        wdata_reg    <= s_axi_wdata;
        wstrb_reg    <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_hold_reg  <= 1'b0;
        w_hold_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awaddr_reg == CTRL_OFS || awaddr_reg == EVT_OFS ||
                         awaddr_reg == EVMASK_OFS) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Control and mask registers.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_reg   <= CTRL_RESET;
      evmask_reg <= '0;
    end
    else if (wr_fire)
    begin
      if (awaddr_reg == CTRL_OFS)
      begin
        if (wstrb_reg[0])
          ctrl_reg[7:0] <= wdata_reg[7:0];
        if (wstrb_reg[1])
          ctrl_reg[8] <= wdata_reg[CTRL_TX_MASK_BIT];
      end
      if (awaddr_reg == EVMASK_OFS && wstrb_reg[0])
        evmask_reg <= wdata_reg[NSRC-1:0];
    end
  end

  assign evt_clr = (wr_fire && awaddr_reg == EVT_OFS && wstrb_reg[0]) ?
                   wdata_reg[NSRC-1:0] : '0;

  // Sticky event bits; a new event wins over a clear.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      evt_reg <= '0;
    else
      evt_reg <= (evt_reg & ~evt_clr) | src;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_reg <= 1'b0;
    else
      irq_reg <= |(((evt_reg & ~evt_clr) | src) & evmask_reg);
  end

  // Read channel.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= 1'b0;
      if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid)
      begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= RESP_OKAY;
        unique case (s_axi_araddr)
          CTRL_OFS:   s_axi_rdata <= {23'h000000, ctrl_reg};
          STATE_OFS:  s_axi_rdata <= {27'h0000000, ~irq_n_reg, flags};
          EVT_OFS:    s_axi_rdata <= {28'h0000000, evt_reg};
          EVMASK_OFS: s_axi_rdata <= {28'h0000000, evmask_reg};
          default:
          begin
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_SLVERR;
          end
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // Interrupt sources, flags and pin checks.
  chk_tx_src_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    uart_in.data_op_done && !(uart_in.tx_empty && !tx_empty_q_reg) |=> !tx_src_reg)
    else $error("tx source not cleared");
  chk_tx_src_set: assert property (@(posedge aclk) disable iff (!aresetn)
    uart_in.tx_empty && !tx_empty_q_reg |=> tx_src_reg)
    else $error("tx source not set");
  chk_tx_irq: assert property (@(posedge aclk) disable iff (!aresetn)
    tx_src_reg && ctrl_reg.tx_empty_irq_mask |=> !irq_n_reg)
    else $error("tx irq missing");
  chk_irq_pin_or: assert property (@(posedge aclk) disable iff (!aresetn)
    src_any |=> !irq_n_reg)
    else $error("irq pin not asserted");
  chk_irq_release: assert property (@(posedge aclk) disable iff (!aresetn)
    !src_any |=> irq_n_reg)
    else $error("irq pin not released");
  chk_parity_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    !ctrl_reg.parity_enable |-> !received_parity_flag)
    else $error("parity flag with parity off");
  chk_parity_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl_reg.parity_enable && uart_in.fifo_valid && !uart_in.fifo_parity |-> !received_parity_flag)
    else $error("parity flag with zero parity");
  chk_parity_irq: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl_reg.parity_enable && uart_in.fifo_valid && uart_in.fifo_parity &&
    ctrl_reg.parity_irq_mask |=> !irq_n_reg)
    else $error("parity irq missing");
  chk_activity_set: assert property (@(posedge aclk) disable iff (!aresetn)
    uart_in.shutdown && shdn_q_reg && (rx_q_reg != uart_in.rx_line) |=> line_activity_flag)
    else $error("line activity missed");
  chk_activity_exit: assert property (@(posedge aclk) disable iff (!aresetn)
    !uart_in.shutdown |=> !line_activity_flag)
    else $error("activity flag outside shutdown");
  chk_activity_irq: assert property (@(posedge aclk) disable iff (!aresetn)
    uart_in.shutdown && line_activity_flag && ctrl_reg.activity_irq_mask |=> !irq_n_reg)
    else $error("activity irq missing");
  chk_shared_bit: assert property (@(posedge aclk) disable iff (!aresetn)
    uart_in.shutdown && shdn_q_reg |-> !framing_error_flag)
    else $error("framing error in shutdown");
  chk_framing_set: assert property (@(posedge aclk) disable iff (!aresetn)
    !uart_in.shutdown && uart_in.stop_sampled && !uart_in.stop_bit |=> framing_error_flag)
    else $error("framing error missed");
  chk_framing_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    !uart_in.shutdown && !uart_in.stop_sampled |=> $stable(framing_error_flag))
    else $error("framing error changed between frames");
  chk_framing_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    !uart_in.shutdown && uart_in.stop_sampled && uart_in.stop_bit |=> !framing_error_flag)
    else $error("framing error kept");
  chk_rx_irq: assert property (@(posedge aclk) disable iff (!aresetn)
    uart_in.fifo_valid && ctrl_reg.receive_irq_mask |=> !irq_n_reg)
    else $error("data irq missing");
  chk_read_irq: assert property (@(posedge aclk) disable iff (!aresetn)
    uart_in.reading && ctrl_reg.receive_irq_mask |=> !irq_n_reg)
    else $error("data irq missing during read");
  chk_ae_irq: assert property (@(posedge aclk) disable iff (!aresetn)
    framing_error_flag && !uart_in.shutdown && ctrl_reg.activity_irq_mask |=> !irq_n_reg)
    else $error("framing irq missing");

  // Main scenarios that the bench is expected to reach.
  cov_tx_irq: cover property (@(posedge aclk) disable iff (!aresetn)
    tx_src_reg && ctrl_reg.tx_empty_irq_mask);
  cov_activity: cover property (@(posedge aclk) disable iff (!aresetn) line_activity_flag);
  cov_framing: cover property (@(posedge aclk) disable iff (!aresetn) framing_error_flag);
  cov_rx_irq: cover property (@(posedge aclk) disable iff (!aresetn) src[SRC_RX]);
  cov_parity_irq: cover property (@(posedge aclk) disable iff (!aresetn) src[SRC_PAR]);

endmodule

// File: logic/ubirq_pkg.sv
package ubirq_pkg;

  localparam int unsigned CLK_HZ = 100000000;

  // Register byte offsets.
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] STATE_OFS  = 8'h04;
  localparam logic [7:0] EVT_OFS    = 8'h08;
  localparam logic [7:0] EVMASK_OFS = 8'h0C;

  // Control register fields.
  localparam int unsigned CTRL_DIV_LSB   = 0;
  localparam int unsigned CTRL_PAR_EN_BIT   = 4;
  localparam int unsigned CTRL_PAR_MASK_BIT = 5;
  localparam int unsigned CTRL_RX_MASK_BIT  = 6;
  localparam int unsigned CTRL_AE_MASK_BIT  = 7;
  localparam int unsigned CTRL_TX_MASK_BIT  = 8;
  localparam logic [8:0]  CTRL_RESET     = 9'h000;

  // Status and event bit positions.
  localparam int unsigned SRC_PAR  = 0;
  localparam int unsigned SRC_RX   = 1;
  localparam int unsigned SRC_AE   = 2;
  localparam int unsigned SRC_TX   = 3;
  localparam int unsigned NSRC     = 4;

  localparam logic [3:0]  DIV_CODE_RESET = 4'h0;
  localparam int unsigned OVERSAMPLE     = 16;
  localparam int unsigned DIV_MAX        = 384;
  localparam int unsigned DIV_W          = 9;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic       tx_empty_irq_mask;
    logic       activity_irq_mask;
    logic       receive_irq_mask;
    logic       parity_irq_mask;
    logic       parity_enable;
    logic [3:0] div_code;
  } ubirq_ctrl_t;

  typedef struct packed {
    logic       fifo_valid;
    logic       fifo_parity;
    logic       reading;
    logic       tx_empty;
    logic       data_op_done;
    logic       shutdown;
    logic       rx_line;
    logic       stop_sampled;
    logic       stop_bit;
  } ubirq_uart_t;

  function automatic logic [DIV_W-1:0] ubirq_divisor(input logic [3:0] code);
    logic [DIV_W-1:0] base;
    base = DIV_W'(1) << code[2:0];
    return code[3] ? DIV_W'(3 * base) : base;
  endfunction

endpackage

// File: logic/ubirq_baudgen.sv
module ubirq_baudgen
  import ubirq_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [3:0] divisor_select_code,
  output logic            tick16_reg
);

  logic [DIV_W-1:0] cnt_reg;
  logic [DIV_W-1:0] div_val;

  assign div_val = ubirq_divisor(divisor_select_code);

  // Counts oscillator cycles up from zero to the selected divisor less one; each tick is one oversample.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_reg    <= '0;
      tick16_reg <= 1'b0;
    end
    else if (cnt_reg >= div_val - DIV_W'(1))
    begin
      cnt_reg    <= '0;
      tick16_reg <= 1'b1;
    end
    else
    begin
      cnt_reg    <= cnt_reg + DIV_W'(1);
      tick16_reg <= 1'b0;
    end
  end

endmodule

// File: test/ubirq_uart_model.sv
module ubirq_uart_model
  import ubirq_pkg::*;
(
  input  wire logic   aclk,
  input  wire logic   aresetn,
  input  wire logic   push,
  input  wire logic   push_par,
  input  wire logic   pop,
  input  wire logic   tx_empty,
  input  wire logic   shutdown,
  input  wire logic   rx_line,
  input  wire logic   frame_end,
  input  wire logic   frame_ok,
  output ubirq_uart_t uart_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic q[$];
  initial uart_out = '0;
  // Outside a valid word or a stop sample the lines show no stale value.
  always @(posedge aclk)
  begin
    if (!aresetn || shutdown)
      q.delete();
    else
    begin
      if (pop && q.size() > 0)
        void'(q.pop_front());
      if (push)
        q.push_back(push_par);
    end
    uart_out.fifo_valid   <= q.size() > 0;
    uart_out.fifo_parity  <= q.size() > 0 ? q[0] : ~uart_out.fifo_parity;
    uart_out.reading      <= pop;
    uart_out.data_op_done <= pop;
    uart_out.tx_empty     <= tx_empty;
    uart_out.shutdown     <= shutdown;
    uart_out.rx_line      <= rx_line;
    uart_out.stop_sampled <= frame_end;
    uart_out.stop_bit     <= frame_end ? frame_ok : ~uart_out.stop_bit;
  end
endmodule

// File: test/ubirq_top_bench.sv
module ubirq_top_bench
  import ubirq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        aclk = 1'h0, aresetn = 1'h0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, tick16_out, irq_n_reg, irq_reg;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic        push = 1'h0, push_par = 1'h0, pop = 1'h0, tx_empty = 1'h0, shutdown = 1'h0;
  logic        rx_line = 1'h1, frame_end = 1'h0, frame_ok = 1'h1, ae = 1'h0, tx_src = 1'h0;
  logic [8:0]  ctrl = 9'h000;
  ubirq_uart_t uart_in;
  int          n_errors = 0, n_tests = 0, seed = 72, cycles = 0, n;
  int          eq[$];
  ubirq_uart_model partner (.aclk, .aresetn, .push, .push_par, .pop, .tx_empty, .shutdown,
    .rx_line, .frame_end, .frame_ok, .uart_out(uart_in));
  ubirq_top uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .uart_in, .tick16_out, .irq_n_reg, .irq_reg);
  always #5 aclk = ~aclk;
  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_errors++;
      summarize();
    end
  end
  task automatic summarize();
    $display("tests=%0d errors=%0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_pin(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw, w, b;
    int   t;
    b = 1'h0;
    t = 0;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid  <= 1'h1;
    s_axi_bready  <= 1'h1;
    while (!b && t < 100)
    begin
      @(negedge aclk);
      t++;
      aw = s_axi_awready;
      w = s_axi_wready;
      b = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'h0;
      if (w) s_axi_wvalid <= 1'h0;
      if (b) s_axi_bready <= 1'h0;
    end
    if (!b) n_errors++;
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar, v;
    int   t;
    ar = 1'h0;
    v = 1'h0;
    t = 0;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready  <= 1'h1;
    while (!v && t < 100)
    begin
      @(negedge aclk);
      t++;
      ar = s_axi_arready;
      v = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ar) s_axi_arvalid <= 1'h0;
      if (v) s_axi_rready <= 1'h0;
    end
    if (!v) n_errors++;
  endtask
  task automatic set_ctrl(input logic [8:0] v);
    ctrl = v;
    axw(CTRL_OFS, {23'h0, v}, rs);
  endtask
  // Kind 0 pushes a word, 1 runs a data operation, 2 ends a frame.
  task automatic core(input int k, input logic v);
    @(posedge aclk);
    push      <= (k == 0);
    push_par  <= v;
    pop       <= (k == 1);
    frame_end <= (k == 2);
    frame_ok  <= v;
    @(posedge aclk);
    push      <= 1'h0;
    pop       <= 1'h0;
    frame_end <= 1'h0;
    if (k == 0) eq.push_back(v);
    if (k == 1 && eq.size() > 0) void'(eq.pop_front());
    if (k == 1) tx_src = 1'h0;
    if (k == 2) ae = !v;
  endtask
  task automatic check_all();
    logic [3:0] s;
    repeat (3) @(posedge aclk);
    s[SRC_PAR] = ctrl[CTRL_PAR_EN_BIT] && eq.size() > 0 && eq[0] != 0;
    s[SRC_RX]  = eq.size() > 0;
    s[SRC_AE]  = ae;
    s[SRC_TX]  = tx_empty;
    axr(STATE_OFS, rd, rs);
    chk(rd, {27'h0, |({tx_src, s[2:0]} & ctrl[8:5]), s});
    chk_pin(irq_n_reg, ~|({tx_src, s[2:0]} & ctrl[8:5]));
  endtask
  task automatic tick_wait();
    n = 0;
    do
    begin
      @(negedge aclk);
      n++;
    end
    while (!tick16_out && n < 1000);
  endtask
  initial
  begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    axr(CTRL_OFS, rd, rs);
    chk(rd, 32'h0);
    chk(32'(rs), 32'(RESP_OKAY));
    check_all();
    axw(STATE_OFS, 32'h1F, rs);
    chk(32'(rs), 32'(RESP_SLVERR));
    axr(8'h10, rd, rs);
    chk(rd, 32'h0);
    chk(32'(rs), 32'(RESP_SLVERR));
    $display("test reset done");
    for (int c = 0; c < 16; c++)
    begin
      set_ctrl(9'(c));
      tick_wait();
      tick_wait();
      tick_wait();
      chk(32'(n), 32'((c[3] ? 3 : 1) << c[2:0]));
    end
    $display("test divisor done");
    for (int m = 0; m < 2; m++)
    begin
      set_ctrl(m ? 9'h050 : 9'h030);
      for (int i = 0; i < 3; i++)
        core(0, 1'($random(seed)));
      check_all();
      set_ctrl(ctrl ^ 9'h010);
      check_all();
      set_ctrl(ctrl ^ 9'h010);
      while (eq.size() > 0)
      begin
        core(1, 1'h0);
        check_all();
      end
      $display("test receive flags done");
    end
    set_ctrl(9'h080);
    axw(EVT_OFS, 32'hF, rs);
    axw(EVMASK_OFS, 32'h4, rs);
    core(2, 1'h0);
    check_all();
    chk_pin(irq_reg, 1'h1);
    set_ctrl(9'h000);
    check_all();
    set_ctrl(9'h080);
    core(2, 1'h1);
    check_all();
    axr(EVT_OFS, rd, rs);
    chk(rd, 32'h4);
    axw(EVT_OFS, 32'h4, rs);
    repeat (2) @(posedge aclk);
    chk_pin(irq_reg, 1'h0);
    $display("test framing done");
    @(posedge aclk);
    shutdown <= 1'h1;
    check_all();
    @(posedge aclk);
    rx_line <= 1'h0;
    ae = 1'h1;
    check_all();
    @(posedge aclk);
    shutdown <= 1'h0;
    ae = 1'h0;
    check_all();
    $display("test shutdown done");
    set_ctrl(9'h100);
    @(posedge aclk);
    tx_empty <= 1'h1;
    tx_src = 1'h1;
    check_all();
    core(1, 1'h0);
    check_all();
    $display("test transmit done");
    summarize();
  end
endmodule
